// File: src/lsp_consts.vh
`ifndef LSP_CONSTS_VH
`define LSP_CONSTS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define LSP_ADDR_CTRL 12'h000
`define LSP_ADDR_ENABLE 12'h004
`define LSP_ADDR_SETPT 12'h008
`define LSP_ADDR_STATUS 12'h00c
`define LSP_ADDR_MASK 12'h010
`define LSP_ADDR_FAULT 12'h014
`define LSP_ADDR_MV_VIDEO 12'h018
`define LSP_ADDR_MV_AUDIO 12'h01c
`define LSP_ADDR_MV_PLL 12'h020
`define LSP_ADDR_MV_DIG 12'h024
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LSP_CTRL_GEN 0
`define LSP_CTRL_CAMPASS 1
`define LSP_STAT_SHORT 0
`define LSP_NREG 7
`define LSP_CAM_IDX 2
`define LSP_SP_VIDEO 1:0
`define LSP_SP_AUDIO 3:2
`define LSP_SP_PLL 5:4
`define LSP_SP_DIG 7:6
`define LSP_SP_W 8
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LSP_RST_ENABLE 7'h00
`define LSP_RST_SETPT 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define LSP_DEBOUNCE_NS 2000
`define LSP_CLK_NS 50
`define LSP_DEBOUNCE_CYC ((`LSP_DEBOUNCE_NS + `LSP_CLK_NS - 1) / `LSP_CLK_NS)
`endif

// File: src/lsp_ctrl.v
// Overview of operation
// RULE_01: Debounced short on an enabled protected regulator clears its enable bit.
// RULE_02: Same event sets the sticky short fault interrupt flag.
// RULE_03: Fault must persist for the debounce interval before acting.
// RULE_04: Mask bit blocks the flag from reaching the interrupt output.
// RULE_05: One global enable arms protection for all protected regulators.
// RULE_06: Global enable clear: no flag set, no enable bit cleared.
// RULE_07: Global enable resets to zero.
// RULE_08: Exactly seven regulators protected: video, audio, camera, card, three general.
// RULE_09: Video set-point codes 00..11 give 2.700, 2.775, 2.500, 2.600 V.
// RULE_10: Audio set-point codes 00..11 give 2.300, 2.500, 2.775, 3.000 V.
// RULE_11: PLL 1.2/1.25/1.5/1.8 V, digital 1.05/1.25/1.65/1.8 V set-points.
// RULE_12: Camera pass select: 0 internal transistor, 1 external drive.
// RULE_13: Camera enable stays clear after reset until software sets it.
// RULE_14: Flag sticky until cleared; regulator stays off until re-enabled.
// RULE_15: Debounce is a fixed count of system clock cycles.
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "lsp_consts.vh"
`default_nettype none
module lsp_ctrl #(
  parameter DEBOUNCE_CYC = `LSP_DEBOUNCE_CYC,
  parameter CW = 8
) (
  input wire sys_clk, // System clock, 20 MHz
  input wire sys_rst, // Async reset, high
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire [6:0] short_detect, // Raw short detectors per regulator
  output reg [6:0] regulator_enable_bit, // Regulator enables
  output reg [7:0] set_point, // Packed set-point fields
  output reg camera_pass_select, // 1 = external transistor drive
  output reg irq // Level interrupt
);
  // Regulator order: 0 video,1 audio,2 camera,3 card,4..6 general one..three
  reg short_protect_global_enable;
  reg short_fault_irq_flag;
  reg short_fault_irq_mask;
  reg [6:0] fault_which;
  wire [6:0] fault_ok;
  reg [31:0] next_prdata;
  reg next_err;
  wire acc = psel & penable & ~pready;
  // Write lands on the edge where the master samples pready high
  wire wr = psel & penable & pready & pwrite;
  wire [6:0] trip = fault_ok & regulator_enable_bit & {7{short_protect_global_enable}}; // RULE_06
  wire clr_flag = wr && paddr == `LSP_ADDR_STATUS && pwdata[`LSP_STAT_SHORT];

  // ----------------------------------------
  // Millivolt decode of a set-point field
  // ----------------------------------------
  function [15:0] mv;
    input [1:0] sel;
    input [1:0] code;
    begin
      case (sel)
        2'h0: case (code) // RULE_09
          2'h0: mv = 16'd2700;
          2'h1: mv = 16'd2775;
          2'h2: mv = 16'd2500;
          default: mv = 16'd2600;
        endcase
        2'h1: case (code) // RULE_10
          2'h0: mv = 16'd2300;
          2'h1: mv = 16'd2500;
          2'h2: mv = 16'd2775;
          default: mv = 16'd3000;
        endcase
        2'h2: case (code) // RULE_11
          2'h0: mv = 16'd1200;
          2'h1: mv = 16'd1250;
          2'h2: mv = 16'd1500;
          default: mv = 16'd1800;
        endcase
        default: case (code) // RULE_11
          2'h0: mv = 16'd1050;
          2'h1: mv = 16'd1250;
          2'h2: mv = 16'd1650;
          default: mv = 16'd1800;
        endcase
      endcase
    end
  endfunction

  // ----------------------------------------
  // Debounce
  // ----------------------------------------
  lsp_debounce #(
    .N(`LSP_NREG),
    .CYC(DEBOUNCE_CYC),
    .CW(CW)
  ) u_deb (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .fault_raw(short_detect), // RULE_08
    .fault_ok(fault_ok)
  );

  // ----------------------------------------
  // Registers and protection
  // ----------------------------------------
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      short_protect_global_enable <= 1'b0; // RULE_07
      short_fault_irq_flag <= 1'b0;
      short_fault_irq_mask <= 1'b0;
      fault_which <= 7'h00;
      regulator_enable_bit <= `LSP_RST_ENABLE; // RULE_13
      set_point <= `LSP_RST_SETPT;
      camera_pass_select <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == `LSP_ADDR_CTRL) begin
        short_protect_global_enable <= pwdata[`LSP_CTRL_GEN]; // RULE_05
        camera_pass_select <= pwdata[`LSP_CTRL_CAMPASS]; // RULE_12
      end
      if (wr && paddr == `LSP_ADDR_SETPT)
        set_point <= pwdata[`LSP_SP_W-1:0];
      if (wr && paddr == `LSP_ADDR_MASK)
        short_fault_irq_mask <= pwdata[`LSP_STAT_SHORT];
      // Trip wins over a same-cycle software enable
      if (wr && paddr == `LSP_ADDR_ENABLE)
        regulator_enable_bit <= pwdata[6:0] & ~trip; // RULE_14
      else
        regulator_enable_bit <= regulator_enable_bit & ~trip; // RULE_01
      if (|trip) begin
        short_fault_irq_flag <= 1'b1; // RULE_02
        fault_which <= fault_which | trip;
      end else if (clr_flag) begin
        short_fault_irq_flag <= 1'b0; // RULE_14
        fault_which <= 7'h00;
      end
      irq <= (short_fault_irq_flag | (|trip)) & ~short_fault_irq_mask; // RULE_04
    end
  end

  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  always @* begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `LSP_ADDR_CTRL: next_prdata = {30'h0, camera_pass_select, short_protect_global_enable};
      `LSP_ADDR_ENABLE: next_prdata = {25'h0, regulator_enable_bit};
      `LSP_ADDR_SETPT: next_prdata = {24'h0, set_point};
      `LSP_ADDR_STATUS: next_prdata = {31'h0, short_fault_irq_flag};
      `LSP_ADDR_MASK: next_prdata = {31'h0, short_fault_irq_mask};
      `LSP_ADDR_FAULT: next_prdata = {25'h0, fault_which};
      `LSP_ADDR_MV_VIDEO: next_prdata = {16'h0, mv(2'h0, set_point[`LSP_SP_VIDEO])};
      `LSP_ADDR_MV_AUDIO: next_prdata = {16'h0, mv(2'h1, set_point[`LSP_SP_AUDIO])};
      `LSP_ADDR_MV_PLL: next_prdata = {16'h0, mv(2'h2, set_point[`LSP_SP_PLL])};
      `LSP_ADDR_MV_DIG: next_prdata = {16'h0, mv(2'h3, set_point[`LSP_SP_DIG])};
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc & next_err;
      if (acc && !pwrite)
        prdata <= next_prdata;
    end
  end
endmodule // lsp_ctrl
`default_nettype wire

// File: src/lsp_debounce.v
`default_nettype none
// ----------------------------------------
// Per-regulator fault debouncer
// ----------------------------------------
module lsp_debounce #(
  parameter N = 7,
  parameter CYC = 40,
  parameter CW = 8
) (
  input wire sys_clk, // System clock
  input wire sys_rst, // Async reset, high
  input wire [N-1:0] fault_raw, // Unsynchronised fault pins
  output reg [N-1:0] fault_ok // Debounced fault, level
);
  localparam [CW-1:0] CYC_LAST = CYC - 1;
  reg [N-1:0] sync1;
  reg [N-1:0] sync2;
  reg [CW-1:0] cnt [0:N-1];
  integer i;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= {N{1'b0}};
      sync2 <= {N{1'b0}};
    end else begin
      sync1 <= fault_raw;
      sync2 <= sync1;
    end
  end
  // Fault must persist CYC cycles before it counts
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_ok <= {N{1'b0}};
      for (i = 0; i < N; i = i + 1) begin
        cnt[i] <= {CW{1'b0}};
      end
    end else begin
      for (i = 0; i < N; i = i + 1) begin
        if (!sync2[i]) begin
          cnt[i] <= {CW{1'b0}};
          fault_ok[i] <= 1'b0;
        end else if (cnt[i] >= CYC_LAST) begin
          fault_ok[i] <= 1'b1; // RULE_03 RULE_15
        end else begin
          cnt[i] <= cnt[i] + 1'b1;
        end
      end
    end
  end
endmodule // lsp_debounce
`default_nettype wire

// File: verif/lsp_ctrl_sva.sv
`default_nettype none
module lsp_ctrl_sva (
  input wire logic sys_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [6:0] short_detect, // Shorts
  input wire logic [6:0] regulator_enable_bit, // Enables
  input wire logic irq // Interrupt
);
  logic gen;
  logic msk;
  wire acc = psel && penable && pwrite && pready;
  wire wr_en = acc && paddr == 12'h004;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gen <= 1'b0;
      msk <= 1'b0;
    end else if (acc) begin
      if (paddr == 12'h000) gen <= pwdata[0];
      if (paddr == 12'h010) msk <= pwdata[0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence apb_wait;
    psel && penable && !pready;
  endsequence
  chk_ready_wait: assert property (apb_wait |=> pready)
    else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  chk_err_unmapped: assert property (pready && paddr > 12'h024 |-> pslverr)
    else $error("no slave error");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_trip_debounced: assert property (!$past(wr_en) |-> ($past(regulator_enable_bit) &
    ~regulator_enable_bit & ~$past(short_detect, 4)) == 7'h00) else $error("early trip");
  chk_enable_sw_only: assert property ((regulator_enable_bit &
    ~$past(regulator_enable_bit)) != 7'h00 |-> $past(wr_en)) else $error("enable rose");
  chk_off_no_trip: assert property (!$past(gen) && !$past(wr_en) |->
    ($past(regulator_enable_bit) & ~regulator_enable_bit) == 7'h00) else $error("trip off");
  chk_trip_irq: assert property (($past(regulator_enable_bit) & ~regulator_enable_bit)
    != 7'h00 && !$past(wr_en) && !msk |-> ##[1:2] irq) else $error("no irq");
  chk_irq_masked: assert property ($past(msk) && msk |-> !irq)
    else $error("masked irq");
endmodule // lsp_ctrl_sva
bind lsp_ctrl lsp_ctrl_sva chk (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .short_detect, .regulator_enable_bit, .irq);
`default_nettype wire

// File: verif/lsp_ctrl_tb.sv
`default_nettype none
`include "lsp_consts.vh"
module lsp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, camera_pass_select, irq;
  logic [6:0] want = '0, short_detect, regulator_enable_bit;
  logic [7:0] set_point;
  int n_mismatch = 0, comparisons = 0;
  int mv[16] = '{2700, 2775, 2500, 2600, 2300, 2500, 2775, 3000,
    1200, 1250, 1500, 1800, 1050, 1250, 1650, 1800};
  lsp_ctrl #(.DEBOUNCE_CYC(4)) dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .short_detect, .regulator_enable_bit, .set_point,
    .camera_pass_select, .irq);
  lsp_fault_src src (.sys_clk, .want, .short_detect);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd, e);
  endtask
  initial begin
    cyc(3);
    sys_rst <= 1'b0;
    rc(`LSP_ADDR_CTRL, '0);
    rc(`LSP_ADDR_ENABLE, '0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `LSP_ADDR_SETPT, {4{c[1:0]}});
      chk(set_point, {4{c[1:0]}});
      for (int j = 0; j < 4; j++) begin
        rc(`LSP_ADDR_MV_VIDEO + 4 * j, mv[c + 4 * j]);
      end
    end
    apb(1'b1, `LSP_ADDR_CTRL, 32'h2);
    chk(camera_pass_select, 1'b1);
    apb(1'b1, `LSP_ADDR_ENABLE, 32'h7f);
    want <= 7'h7f;
    cyc(30);
    want <= '0;
    chk(regulator_enable_bit, 7'h7f);
    chk(irq, 1'b0);
    cyc(10);
    apb(1'b1, `LSP_ADDR_CTRL, 32'h1);
    chk(camera_pass_select, 1'b0);
    want <= 7'h7f;
    cyc(2);
    want <= '0;
    cyc(20);
    chk(regulator_enable_bit, 7'h7f);
    for (int i = 0; i < 7; i++) begin
      want <= 7'h01 << i;
      cyc(20);
      want <= '0;
      cyc(10);
      chk(regulator_enable_bit, 7'h7f ^ (7'h01 << i));
      chk(irq, 1'b1);
      rc(`LSP_ADDR_STATUS, 32'h1);
      rc(`LSP_ADDR_FAULT, 32'h1 << i);
      apb(1'b1, `LSP_ADDR_STATUS, 32'h1);
      cyc(2);
      chk(irq, 1'b0);
      apb(1'b1, `LSP_ADDR_ENABLE, 32'h7f);
    end
    apb(1'b1, `LSP_ADDR_MASK, 32'h1);
    want <= 7'h04;
    cyc(20);
    want <= '0;
    chk(irq, 1'b0);
    chk(regulator_enable_bit, 7'h7b);
    apb(1'b1, `LSP_ADDR_MASK, 32'h0);
    cyc(2);
    chk(irq, 1'b1);
    apb(1'b1, 12'h100, 32'h1);
    chk(err, 1'b1);
    rc(12'h100, '0);
    conclude();
  end
endmodule // lsp_ctrl_tb
`default_nettype wire

// File: verif/lsp_fault_src.sv
`default_nettype none
module lsp_fault_src (
  input wire logic sys_clk, // Clock
  input wire logic [6:0] want, // Requested shorts
  output logic [6:0] short_detect = 7'h00 // Short pins
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge sys_clk) short_detect <= want;
endmodule // lsp_fault_src
`default_nettype wire
